// ==== rtl/hold_load_register.sv ====
// Purpose: One side's lane register with hold, load and scan shift.
// Assumes: Load and scan controls are already synchronous to the clock.
// Notes:   Scan shift has priority over load; holding recirculates the value.
`timescale 1ns/1ps
module hold_load_register
  import xcvr_pkg::*;
#(
  parameter int WIDTH = LANES
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             scan_i,
  input  wire logic             load_i,
  input  wire logic             serial_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] q_o
);

  // Bit 0 takes the serial input and the top bit is the chain's far end.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q_o <= LANE_RESET;
    end else if (scan_i) begin
      q_o <= {q_o[WIDTH-2:0], serial_i};
    end else if (load_i) begin
      q_o <= data_i;
    end else begin
      q_o <= q_o;
    end
  end

endmodule

// ==== rtl/scannable_bus_transceiver.sv ====
// Purpose: Three-lane registered bus transceiver with scan and bus enables.
// Assumes: Pin inputs are asynchronous; the register bus is AHB-Lite.
// Notes:   Received words are queued for software in a 16-word FIFO.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - Three lanes, transmit and receive registers each.
// - All storage updates on rising clock edge.
// - Low bus output releases the bus line.
// - Both sides share identical hold-loop register logic.
// - High load control loads, low control holds; a full FIFO makes the receive side hold.
// - Clocked bus enable sampled outside scan mode.
// - Immediate disable releases bus outputs at once.
// - Mode input picks clocked or asynchronous re-enable.
// - Mode input low sets enable flop, overriding.
// - Scan control high shifts registers as chain.
// - Scan data enters from serial shift input.
// - Top receive output carries chain end.
// - Data path never inverts.
module scannable_bus_transceiver
  import xcvr_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // AHB-Lite slave port.
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  // Transmit data and controls.
  input  wire logic [LANES-1:0] first_data_inputs_i,
  input  wire logic [LANES-1:0] second_data_inputs_i,
  input  wire logic             transmit_load_control_i,
  input  wire logic             receive_load_control_i,
  // Scan controls.
  input  wire logic             scan_mode_i,
  input  wire logic             scan_serial_i,
  // Bus enable controls.
  input  wire logic             clocked_bus_enable_i,
  input  wire logic             immediate_bus_disable_i,
  input  wire logic             reenable_mode_select_n_i,
  // Shared bus lines, split into level, drive value and enable.
  input  wire logic [LANES-1:0] cutoff_bus_in_i,
  output logic      [LANES-1:0] cutoff_bus_outputs_o,
  output logic      [LANES-1:0] cutoff_bus_oe_n_o,
  // Receive data outputs; the top bit is the scan output in scan mode.
  output logic      [LANES-1:0] receive_outputs_o
);

  // Width of the bundle of pin inputs that pass the synchroniser.
  localparam int SYNC_W = 3 * LANES + 7;
  // Reset value of the bundle: the active-low mode select idles high, so a
  // zero here would falsely set the enable flop right after reset.
  localparam logic [SYNC_W-1:0] SYNC_RESET = {{(SYNC_W-LANES-1){1'b0}}, 1'b1, {LANES{1'b0}}};

  // Synchroniser stages; the first is read only by the second.
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;

  // Synchronised copies of the pin inputs.
  logic [LANES-1:0] s_first;      // First data group.
  logic [LANES-1:0] s_second;     // Second data group.
  logic             s_serial;     // Scan serial data.
  logic             s_tx_load;    // Transmit load control.
  logic             s_rx_load;    // Receive load control.
  logic             s_scan;       // Scan mode control.
  logic             s_bus_en;     // Clocked bus enable.
  logic             s_disable;    // Immediate disable, clocked copy.
  logic             s_sel_n;      // Re-enable mode select, clocked copy.
  logic [LANES-1:0] s_bus;        // Bus line levels.

  // Lane registers and the enable flip-flop.
  logic [LANES-1:0] tx_q;         // Transmit register.
  logic [LANES-1:0] rx_q;         // Receive register.
  logic             enable_q;     // Bus enable flip-flop.
  logic             bus_drive;    // Bus drive permission, after overrides.
  logic [LANES-1:0] tx_data;      // Word offered to the transmit register.
  logic             rx_load_go;   // Receive register loads this cycle.

  // Software control state.
  logic             sw_source;    // Transmit data comes from software.
  logic [LANES-1:0] sw_data;      // Software transmit word.

  // Receive FIFO handshakes.
  logic               push_valid;
  logic               push_ready;
  logic               pop_valid;
  logic               pop_ready;
  logic [LANES-1:0]   pop_data;
  logic [COUNT_W-1:0] fifo_count;

  // Bus slave state.
  logic                accept;      // An address phase is taken this cycle.
  logic                wr_pending;  // A write data phase is in progress.
  logic [DECODE_W-1:0] wr_addr;     // Offset of the pending write.
  logic                wr_ctrl_now; // The pending write targets control.
  logic                view_source; // Control source bit as software sees it.
  logic [LANES-1:0]    view_data;   // Control data field as software sees it.
  logic [31:0]         next_rdata;  // Read word chosen at the address phase.
  logic [DECODE_W-1:0] acc_addr;    // Decoded offset of the address phase.

  // Every pin input crosses into the clock domain through two flops.
  // This costs two cycles of latency on loads but removes metastability.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_meta <= SYNC_RESET;
      pin_sync <= SYNC_RESET;
    end else begin
      pin_meta <= {first_data_inputs_i, second_data_inputs_i, scan_serial_i,
                   transmit_load_control_i, receive_load_control_i, scan_mode_i,
                   clocked_bus_enable_i, immediate_bus_disable_i,
                   reenable_mode_select_n_i, cutoff_bus_in_i};
      pin_sync <= pin_meta;
    end
  end

  // Unpack the synchronised bundle in the same order it was packed.
  assign {s_first, s_second, s_serial, s_tx_load, s_rx_load, s_scan,
          s_bus_en, s_disable, s_sel_n, s_bus} = pin_sync;

  // The transmit word is the OR of both groups, unless software supplies it.
  // Both paths keep the true sense of every bit.
  always_comb begin
    if (sw_source) begin
      tx_data = sw_data;
    end else begin
      tx_data = s_first | s_second;
    end
  end

  // Transmit side; the chain starts at its bit 0 from the serial input.
  hold_load_register #(
    .WIDTH (LANES)
  ) u_tx_register (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .scan_i    (s_scan),
    .load_i    (s_tx_load),
    .serial_i  (s_serial),
    .data_i    (tx_data),
    .q_o       (tx_q)
  );

  // A receive load is a FIFO push; a full FIFO refuses the load, so the
  // word on the bus is not captured and the register holds instead.
  assign push_valid = s_rx_load & ~s_scan;
  assign rx_load_go = push_valid & push_ready;

  // Receive side; it continues the chain from the top transmit bit.
  hold_load_register #(
    .WIDTH (LANES)
  ) u_rx_register (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .scan_i    (s_scan),
    .load_i    (rx_load_go),
    .serial_i  (tx_q[LANES-1]),
    .data_i    (s_bus),
    .q_o       (rx_q)
  );

  // Receive outputs come straight from the receive register flops, so in
  // scan mode the top bit is the last stage of the chain.
  assign receive_outputs_o = rx_q;

  // Received words queue here until software reads them.
  word_fifo #(
    .WIDTH (LANES),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (s_bus),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data),
    .count_o     (fifo_count)
  );

  // Enable flip-flop. A low mode select sets it and overrides all else;
  // a disable clears it so that clocked re-enable needs a fresh sample;
  // otherwise it samples the clocked enable, but only outside scan mode.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      enable_q <= ENABLE_RESET;
    end else if (!s_sel_n) begin
      enable_q <= 1'b1;
    end else if (s_disable) begin
      enable_q <= 1'b0;
    end else if (!s_scan) begin
      enable_q <= s_bus_en;
    end
  end

  // The disable and the set act on the pins without waiting for an edge,
  // which is why these raw levels bypass the synchroniser here. Nothing
  // stores them: they only gate the drive permission.
  assign bus_drive = (enable_q | ~reenable_mode_select_n_i)
                   & ~immediate_bus_disable_i;

  // A high bit is driven; a low bit, or any bit without permission,
  // releases the line so other transceivers on the bus can pull it.
  assign cutoff_bus_outputs_o = tx_q;
  assign cutoff_bus_oe_n_o    = ~(tx_q & {LANES{bus_drive}});

  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = HRESP_OKAY;

  // An address phase counts only when selected, NONSEQ (not SEQ or BUSY) and bus ready.
  assign accept   = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
  assign acc_addr = haddr_i[DECODE_W-1:0];

  // A FIFO read pops at its address phase, so the word is latched then.
  assign pop_ready = accept & ~hwrite_i & (acc_addr == RX_FIFO_OFFSET);

  // Write data arrive one cycle after the address, so remember the target.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end else begin
      wr_pending <= accept & hwrite_i;
      if (accept) begin
        wr_addr <= acc_addr;
      end
    end
  end

  // A write to control is landing in the current data phase.
  assign wr_ctrl_now = wr_pending & (wr_addr == CTRL_OFFSET);

  // Forward a landing control write so that a read right behind it
  // returns the new value rather than the stale one.
  always_comb begin
    if (wr_ctrl_now) begin
      view_source = hwdata_i[CTRL_SW_SOURCE_BIT];
      view_data   = hwdata_i[CTRL_SW_DATA_LSB +: LANES];
    end else begin
      view_source = sw_source;
      view_data   = sw_data;
    end
  end

  // Control register; only word writes are issued by the master, and
  // other sizes are still taken as whole words.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sw_source <= CTRL_SW_SOURCE_RESET;
      sw_data   <= LANE_RESET;
    end else if (wr_ctrl_now) begin
      sw_source <= hwdata_i[CTRL_SW_SOURCE_BIT];
      sw_data   <= hwdata_i[CTRL_SW_DATA_LSB +: LANES];
    end
  end

  // Read word for the address phase; unmapped offsets read as zero.
  always_comb begin
    next_rdata = '0;
    unique case (acc_addr)
      CTRL_OFFSET: begin
        next_rdata[CTRL_SW_SOURCE_BIT]          = view_source;
        next_rdata[CTRL_SW_DATA_LSB +: LANES]   = view_data;
      end
      STATUS_OFFSET: begin
        next_rdata[STATUS_TX_LSB +: LANES]      = tx_q;
        next_rdata[STATUS_RX_LSB +: LANES]      = rx_q;
        next_rdata[STATUS_ENABLE_BIT]           = enable_q;
        next_rdata[STATUS_DRIVE_BIT]            = bus_drive;
        next_rdata[STATUS_SCAN_BIT]             = s_scan;
        next_rdata[STATUS_FULL_BIT]             = ~push_ready;
        next_rdata[STATUS_COUNT_LSB +: COUNT_W] = fifo_count;
      end
      RX_FIFO_OFFSET: begin
        next_rdata[RX_FIFO_VALID_BIT]           = pop_valid;
        next_rdata[RX_FIFO_DATA_LSB +: LANES]   = pop_valid ? pop_data : LANE_RESET;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data are captured at the address phase and stand in the data
  // phase; they hold until the next accepted read replaces them.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hrdata_o <= '0;
    end else if (accept && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  // The transfer size is not checked; only whole words are expected.
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize_i, haddr_i[31:DECODE_W]};

endmodule

// ==== rtl/word_fifo.sv ====
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Push and pop are in the same clock domain.
// Notes:   Full and empty come straight from the occupancy count.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 16
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic      [WIDTH-1:0]           out_data_o,
  output logic      [$clog2(DEPTH+1)-1:0] count_o
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
  logic [PTR_W-1:0] wr_ptr;       // Next slot to write.
  logic [PTR_W-1:0] rd_ptr;       // Oldest stored slot.
  logic             push;         // A word enters this cycle.
  logic             pop;          // A word leaves this cycle.

  assign in_ready_o  = (count_o != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (count_o != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage has no reset; only slots below the count are ever read.
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count_o <= count_o + 1'b1;
      end else if (pop && !push) begin
        count_o <= count_o - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/xcvr_pkg.sv ====
// Purpose: Shared constants for the scannable registered bus transceiver.
// Assumes: One 20 MHz clock and a synchronous, active-high reset.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package xcvr_pkg;

  // Number of bit lanes on the transceiver.
  localparam int LANES = 3;
  // Depth of the receive word FIFO.
  localparam int FIFO_DEPTH = 16;
  // Width of the FIFO occupancy count.
  localparam int COUNT_W = $clog2(FIFO_DEPTH + 1);

  // Clock period in nanoseconds, kept for reference by timing users.
  localparam int CLK_PERIOD_NS = 50;

  // Number of low address bits that take part in register decode.
  localparam int DECODE_W = 8;
  // Register byte offsets.
  localparam logic [DECODE_W-1:0] CTRL_OFFSET    = 8'h00;
  localparam logic [DECODE_W-1:0] STATUS_OFFSET  = 8'h04;
  localparam logic [DECODE_W-1:0] RX_FIFO_OFFSET = 8'h08;

  // Control register fields.
  localparam int CTRL_SW_SOURCE_BIT = 0;
  localparam int CTRL_SW_DATA_LSB   = 4;
  localparam logic CTRL_SW_SOURCE_RESET = 1'h0;

  // Status register fields.
  localparam int STATUS_TX_LSB     = 0;
  localparam int STATUS_RX_LSB     = 4;
  localparam int STATUS_ENABLE_BIT = 8;
  localparam int STATUS_DRIVE_BIT  = 9;
  localparam int STATUS_SCAN_BIT   = 10;
  localparam int STATUS_FULL_BIT   = 11;
  localparam int STATUS_COUNT_LSB  = 16;

  // Receive FIFO register fields.
  localparam int RX_FIFO_DATA_LSB  = 0;
  localparam int RX_FIFO_VALID_BIT = 31;

  // Reset values of the lane registers and the bus enable flip-flop.
  localparam logic [LANES-1:0] LANE_RESET   = '0;
  localparam logic             ENABLE_RESET = 1'h0;

  // Bus transfer type and response codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ==== tb/backplane_peer.sv ====
// Purpose: Another transceiver on the shared cutoff bus.
// Assumes: The peer updates its drive value on the common clock.
// Notes:   Lines nobody drives fall to the terminated low level.
`timescale 1ns/1ps
module backplane_peer
  import xcvr_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic [LANES-1:0] peer_value_i,
  input  wire logic [LANES-1:0] dut_value_i,
  input  wire logic [LANES-1:0] dut_oe_n_i,
  output logic      [LANES-1:0] bus_level_o
);
  // The peer's own transmit register.
  logic [LANES-1:0] peer_q = '0;

  // Registered like a real transceiver, so changes land on an edge.
  always_ff @(posedge ref_clk_i) begin
    peer_q <= peer_value_i;
  end

  // Wire-OR of all drivers; a released line is pulled low, never left floating.
  assign bus_level_o = (~dut_oe_n_i & dut_value_i) | peer_q;
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the scannable bus transceiver.
// Assumes: Pins act two edges after they are seen; zero-wait bus slave.
// Notes:   Scan runs last because it scrambles both lane registers.
`timescale 1ns/1ps
module tb
  import xcvr_pkg::*;
;
  logic             ref_clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0]      haddr_i, hwdata_i, hrdata_o;
  logic [1:0]       htrans_i;
  logic [2:0]       hsize_i;
  logic [LANES-1:0] first_i, second_i, peer_val, bus_level, bus_out, oe_n, rx_q;
  logic             tx_load, rx_load, scan, serial, enable, dis_now, sel_n;
  int               failures, n_checks;

  scannable_bus_transceiver i_scannable_bus_transceiver (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .first_data_inputs_i(first_i), .second_data_inputs_i(second_i),
    .transmit_load_control_i(tx_load), .receive_load_control_i(rx_load),
    .scan_mode_i(scan), .scan_serial_i(serial), .clocked_bus_enable_i(enable),
    .immediate_bus_disable_i(dis_now), .reenable_mode_select_n_i(sel_n),
    .cutoff_bus_in_i(bus_level), .cutoff_bus_outputs_o(bus_out), .cutoff_bus_oe_n_o(oe_n),
    .receive_outputs_o(rx_q)
  );

  backplane_peer i_backplane_peer (
    .ref_clk_i(ref_clk_i), .peer_value_i(peer_val), .dut_value_i(bus_out),
    .dut_oe_n_i(oe_n), .bus_level_o(bus_level)
  );

  // Free-running 20 MHz clock.
  always #25 ref_clk_i = ~ref_clk_i;

  // Widens a lane value without letting inversion spread into upper bits.
  function automatic logic [31:0] w3(input logic [2:0] v);
    return {29'h0, v};
  endfunction

  // Counts every comparison and reports a mismatch at once.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task edges(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // One single AHB-Lite transfer; entered right after a rising edge.
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= HTRANS_NONSEQ;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 50);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 50);
    rd = hrdata_o;
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  task t_reset;
    #1;
    check(w3(rx_q), w3(3'h0));
    check(w3(oe_n), w3(3'h7));
    $display("reset test done");
  endtask

  // Read-back, a software-sourced load, and an ignored unmapped write.
  task t_regs;
    logic [31:0] r;
    edges(1);
    rd_chk(32'(CTRL_OFFSET), 32'h0);
    xfer(1'b1, 32'(CTRL_OFFSET), 32'h51, r);
    rd_chk(32'(CTRL_OFFSET), 32'h51);
    tx_load <= 1'b1;
    edges(3);
    #1;
    check(w3(bus_out), w3(3'h5));
    edges(1);
    tx_load <= 1'b0;
    xfer(1'b1, 32'(CTRL_OFFSET), 32'h0, r);
    xfer(1'b1, 32'h0C, 32'hFFFFFFFF, r);
    rd_chk(32'h0C, 32'h0);
    $display("register test done");
  endtask

  // Each lane loads the OR of both groups, uninverted, and then holds.
  task t_transmit;
    logic [2:0] av [3] = '{3'h5, 3'h0, 3'h1};
    logic [2:0] bv [3] = '{3'h0, 3'h2, 3'h6};
    for (int i = 0; i < 3; i++) begin
      edges(1);
      first_i <= av[i];
      second_i <= bv[i];
      tx_load <= 1'b1;
      edges(3);
      #1;
      check(w3(bus_out), w3(av[i] | bv[i]));
      check(w3(oe_n), w3(~(av[i] | bv[i])));
    end
    edges(1);
    tx_load <= 1'b0;
    first_i <= 3'h0;
    second_i <= 3'h0;
    edges(4);
    #1;
    check(w3(bus_out), w3(3'h7));
    $display("transmit test done");
  endtask

  // Immediate disable, clocked re-enable and asynchronous re-enable.
  task t_enable;
    edges(1);
    dis_now <= 1'b1;
    enable <= 1'b0;
    #1;
    check(w3(oe_n), w3(3'h7));
    edges(4);
    dis_now <= 1'b0;
    edges(4);
    #1;
    check(w3(oe_n), w3(3'h7));
    edges(1);
    enable <= 1'b1;
    edges(3);
    #1;
    check(w3(oe_n), w3(3'h0));
    edges(1);
    dis_now <= 1'b1;
    enable <= 1'b0;
    edges(4);
    dis_now <= 1'b0;
    edges(4);
    #1;
    check(w3(oe_n), w3(3'h7));
    edges(1);
    sel_n <= 1'b0;
    #1;
    check(w3(oe_n), w3(3'h0));
    edges(1);
    enable <= 1'b1;
    edges(3);
    sel_n <= 1'b1;
    edges(3);
    #1;
    check(w3(oe_n), w3(3'h0));
    $display("enable test done");
  endtask

  // A one-cycle receive load captures the bus and queues one word.
  task t_receive;
    logic [31:0] r;
    edges(1);
    tx_load <= 1'b1;
    peer_val <= 3'h2;
    edges(4);
    tx_load <= 1'b0;
    rx_load <= 1'b1;
    edges(1);
    rx_load <= 1'b0;
    edges(5);
    #1;
    check(w3(rx_q), w3(3'h2));
    edges(1);
    peer_val <= 3'h5;
    edges(6);
    #1;
    check(w3(rx_q), w3(3'h2));
    edges(1);
    rd_chk(32'(RX_FIFO_OFFSET), 32'h80000002);
    xfer(1'b0, 32'(RX_FIFO_OFFSET), 32'h0, r);
    check({31'h0, r[RX_FIFO_VALID_BIT]}, 32'h0);
    $display("receive test done");
  endtask

  // Loads until the queue refuses, then drains it to empty.
  task t_fifo;
    logic [31:0] r;
    edges(1);
    peer_val <= 3'h3;
    edges(4);
    rx_load <= 1'b1;
    edges(24);
    rx_load <= 1'b0;
    edges(4);
    xfer(1'b0, 32'(STATUS_OFFSET), 32'h0, r);
    check({31'h0, r[STATUS_FULL_BIT]}, 32'h1);
    check({27'h0, r[STATUS_COUNT_LSB +: COUNT_W]}, 32'(FIFO_DEPTH));
    repeat (FIFO_DEPTH) rd_chk(32'(RX_FIFO_OFFSET), 32'h80000003);
    xfer(1'b0, 32'(RX_FIFO_OFFSET), 32'h0, r);
    check({31'h0, r[RX_FIFO_VALID_BIT]}, 32'h0);
    $display("fifo test done");
  endtask

  // A serial pattern must reach the top receive output eight edges later.
  task t_scan;
    logic [23:0] p = 24'hB35AC6;
    for (int j = 0; j < 24; j++) begin
      edges(1);
      scan <= 1'b1;
      serial <= p[j];
      #1;
      if (j >= 8) check({31'h0, rx_q[2]}, {31'h0, p[j-8]});
    end
    edges(1);
    scan <= 1'b0;
    $display("scan test done");
  endtask

  task finish_test;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial begin
    edges(20000);
    failures++;
    finish_test;
  end

  initial begin
    ref_clk_i = 1'b0;
    reset_i = 1'b1;
    {hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
    hsize_i = 3'h2;
    {first_i, second_i, peer_val, tx_load, rx_load, scan, serial, dis_now} = '0;
    enable = 1'b1;
    sel_n = 1'b1;
    failures = 0;
    n_checks = 0;
    edges(5);
    reset_i <= 1'b0;
    t_reset;
    t_regs;
    t_transmit;
    t_enable;
    t_receive;
    t_fifo;
    t_scan;
    finish_test;
  end
endmodule

// ==== tb/xcvr_props.sv ====
// Purpose: Port-level checks for the scannable bus transceiver.
// Assumes: Pin inputs pass two synchroniser stages before they act.
// Notes:   Checks see the pins and the bus ready and response outputs, never the rest of the register bus.
`timescale 1ns/1ps
module xcvr_props
  import xcvr_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             hreadyout_o,
  input  wire logic             hresp_o,
  input  wire logic             transmit_load_control_i,
  input  wire logic             receive_load_control_i,
  input  wire logic             scan_mode_i,
  input  wire logic             scan_serial_i,
  input  wire logic             clocked_bus_enable_i,
  input  wire logic             immediate_bus_disable_i,
  input  wire logic             reenable_mode_select_n_i,
  input  wire logic [LANES-1:0] cutoff_bus_outputs_o,
  input  wire logic [LANES-1:0] cutoff_bus_oe_n_o,
  input  wire logic [LANES-1:0] receive_outputs_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // Three quiet samples cover the two synchroniser stages.
  sequence rx_quiet;
    !receive_load_control_i && !scan_mode_i;
  endsequence
  sequence tx_quiet;
    !transmit_load_control_i && !scan_mode_i;
  endsequence
  // Only the clocked enable path is in charge of the enable flop.
  sequence en_off;
    !clocked_bus_enable_i && reenable_mode_select_n_i && !immediate_bus_disable_i && !scan_mode_i;
  endsequence
  sequence en_on;
    clocked_bus_enable_i && reenable_mode_select_n_i && !immediate_bus_disable_i && !scan_mode_i;
  endsequence

  a_bus_ready_okay:
    assert property (hreadyout_o && hresp_o == HRESP_OKAY) else $error("slave stalled or erred");
  a_low_not_driven:
    assert property ((~cutoff_bus_oe_n_o & ~cutoff_bus_outputs_o) == '0) else $error("low level driven");
  a_disable_releases:
    assert property (immediate_bus_disable_i |-> &cutoff_bus_oe_n_o) else $error("bus kept under disable");
  a_async_set_drives:
    assert property (!reenable_mode_select_n_i && !immediate_bus_disable_i
      |-> cutoff_bus_oe_n_o == ~cutoff_bus_outputs_o) else $error("async set did not drive");
  a_clocked_off_cuts:
    assert property (en_off[*4] |-> &cutoff_bus_oe_n_o) else $error("bus driven while disabled");
  a_clocked_on_drives:
    assert property (en_on[*4] |-> cutoff_bus_oe_n_o == ~cutoff_bus_outputs_o) else $error("enabled bus idle");
  a_rx_holds_value:
    assert property (rx_quiet[*3] |=> $stable(receive_outputs_o)) else $error("receive register moved");
  a_tx_holds_value:
    assert property (tx_quiet[*3] |=> $stable(cutoff_bus_outputs_o)) else $error("transmit register moved");
  a_scan_out_chain:
    assert property (scan_mode_i[*8] |=> receive_outputs_o[2] == $past(scan_serial_i, 8))
      else $error("scan output out of order");
endmodule

bind scannable_bus_transceiver xcvr_props i_xcvr_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .transmit_load_control_i(transmit_load_control_i), .receive_load_control_i(receive_load_control_i),
  .scan_mode_i(scan_mode_i), .scan_serial_i(scan_serial_i), .clocked_bus_enable_i(clocked_bus_enable_i),
  .immediate_bus_disable_i(immediate_bus_disable_i), .reenable_mode_select_n_i(reenable_mode_select_n_i),
  .cutoff_bus_outputs_o(cutoff_bus_outputs_o), .cutoff_bus_oe_n_o(cutoff_bus_oe_n_o),
  .receive_outputs_o(receive_outputs_o)
);
